// [verilog/dpll_cfg_map.svh]
// Purpose: offsets, field positions, reset values for the address and pll input registers
// Assumes: byte-wide registers reached by a serial-interface register port
// Notes:   definitions only
`ifndef DPLL_CFG_MAP_SVH
`define DPLL_CFG_MAP_SVH

`define OFS_OWN_ADDR      8'h06
`define OFS_SER_RSVD      8'h07
`define OFS_REF_FB_SEL    8'h08
`define OFS_PRIMARY_REF   8'h09
`define OFS_REF_DIS_STATE 8'h0a
`define OFS_PREDIV_HIGH   8'h0b
`define OFS_PREDIV_MID    8'h0c
`define OFS_PREDIV_LOW    8'h0d

`define RST_ADDR_UPPER    5'h1f
`define RST_REF_CHOICE    3'h0
`define RST_FB_CHOICE     3'h0
`define RST_REVERTIVE     1'h1
`define RST_SWITCHOVER_PHASE_BEHAVIOUR        1'h1
`define RST_PRIMARY       1'h0
`define RST_EXCLUDE       1'h0
`define RST_STATE_CTRL    2'h0
`define RST_PREDIV        21'h000000

`define BIT_REF1_EXCLUDE  5
`define BIT_REF0_EXCLUDE  4

`endif

// [verilog/dpll_cfg_pkg.sv]
// Purpose: shared types of the address and pll input register slice
// Assumes: nothing beyond the map header
// Notes:   modes are enums, configuration travels as one packed struct
package dpll_cfg_pkg;

  typedef enum logic [2:0] {
    REF_AUTO       = 3'h0,
    REF_BY_GPIO    = 3'h1,
    REF_FORCE_0    = 3'h4,
    REF_FORCE_1    = 3'h5
  } ref_choice_t;

  typedef enum logic [1:0] {
    ST_AUTO        = 2'h0,
    ST_FREE_RUN    = 2'h1,
    ST_NORMAL      = 2'h2,
    ST_HELD_FREQ   = 2'h3
  } state_ctrl_t;

  typedef struct packed {
    logic [2:0]  pll_reference_choice;
    logic [2:0]  pll_feedback_choice;
    logic        revertive_switch_enable;
    logic        switchover_phase_behaviour;
    logic        primary_reference_choice;
    logic        reference1_exclude;
    logic        reference0_exclude;
    logic [1:0]  state_ctrl;
    logic [20:0] reference0_predivider;
  } pll_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [verilog/pll_mode_decode.sv]
// Purpose: decode the reference-select and state-control codes into one-hot controls
// Assumes: codes come straight from the register file
// Notes:   illegal reference codes fall back to automatic and raise a flag
`include "dpll_cfg_map.svh"
module pll_mode_decode (
  input  wire logic [2:0] ref_code_in,
  input  wire logic [1:0] state_code_in,
  input  wire logic       primary_in,
  output logic            ref_auto_out,
  output logic            ref_gpio_out,
  output logic            force_ref0_out,
  output logic            force_ref1_out,
  output logic            ref_code_bad_out,
  output logic            primary_is_ref1_out,
  output logic [3:0]      state_force_out
);
  wire ref_is_legal;

  // unused codes are treated as automatic so the loop never loses its reference
  assign ref_is_legal     = (ref_code_in == dpll_cfg_pkg::REF_AUTO) || (ref_code_in == dpll_cfg_pkg::REF_BY_GPIO) ||
                            (ref_code_in == dpll_cfg_pkg::REF_FORCE_0) ||
                            (ref_code_in == dpll_cfg_pkg::REF_FORCE_1);
  assign ref_code_bad_out = !ref_is_legal;
  assign ref_auto_out     = !ref_is_legal || (ref_code_in == dpll_cfg_pkg::REF_AUTO);
  assign ref_gpio_out     = (ref_code_in == dpll_cfg_pkg::REF_BY_GPIO);
  assign force_ref0_out   = (ref_code_in == dpll_cfg_pkg::REF_FORCE_0);
  assign force_ref1_out   = (ref_code_in == dpll_cfg_pkg::REF_FORCE_1);
  // 0 = clock 0 primary, 1 = clock 1 primary
  assign primary_is_ref1_out = primary_in;

  // one-hot: auto, free running, normal, held frequency
  assign state_force_out = 4'h1 << state_code_in;
endmodule

// [verilog/dpll_input_regs.sv]
// Purpose: own-address register and digital pll input control registers
// Assumes: byte register port from the serial-interface engine, clock_in 20 MHz
// Notes:   all outputs registered; strap pins sampled each cycle
//
// Contract
// - writable address bits 6:2, bit 7 zero
// - address bits 1:0 mirror strap pins, read-only
// - generic power-up address is 1111100b
// - register 08 holds pll_reference_feedback_select, revert, mode
// - primary ref, disables, state, 21-bit predivider
// - reference-select codes decode; unused codes avoided; unused codes are stored and decode as automatic with ref_code_bad_out set
// - state field forces free-run, normal, held_frequency_state
// - primary bit picks clock 0 or 1
// - predivider sets ref 0 ratio, resets zero
`include "dpll_cfg_map.svh"
module dpll_input_regs (
  input  wire logic                     clock_in,
  input  wire logic                     rst_in,
  input  wire dpll_cfg_pkg::reg_req_t   req_in,
  input  wire logic                     address_strap_pin_1_in,
  input  wire logic                     address_strap_pin_0_in,
  output logic [7:0]                    rdata_out,
  output logic                          rvalid_out,
  output logic [6:0]                    own_bus_target_address_out,
  output dpll_cfg_pkg::pll_cfg_t        pll_cfg_out,
  output logic                          ref_auto_out,
  output logic                          ref_gpio_out,
  output logic                          force_ref0_out,
  output logic                          force_ref1_out,
  output logic                          ref_code_bad_out,
  output logic                          primary_is_ref1_out,
  output logic [3:0]                    state_force_out
);
  logic [4:0]             addr_upper_ff;
  logic [1:0]             strap_ff;
  dpll_cfg_pkg::pll_cfg_t cfg_ff;
  logic [7:0]             rdata_ff;
  logic                   rvalid_ff;
  logic                   ref_auto_ff;
  logic                   ref_gpio_ff;
  logic                   force_ref0_ff;
  logic                   force_ref1_ff;
  logic                   ref_code_bad_ff;
  logic                   primary_ff;
  logic [3:0]             state_force_ff;

  wire                    wr_own;
  wire                    wr_sel;
  wire                    wr_pri;
  wire                    wr_dis;
  wire                    wr_ph;
  wire                    wr_pm;
  wire                    wr_pl;
  wire                    sel_own;
  wire                    sel_refs;
  wire                    sel_pri;
  wire                    sel_dis;
  wire                    sel_ph;
  wire                    sel_pm;
  wire                    sel_pl;
  wire [7:0]              nxt_rdata;
  dpll_cfg_pkg::pll_cfg_t nxt_cfg;
  wire                    dec_auto;
  wire                    dec_gpio;
  wire                    dec_f0;
  wire                    dec_f1;
  wire                    dec_bad;
  wire                    dec_pri;
  wire [3:0]              dec_state;

  // offset decode shared by write strobes and read mux, so the two cannot drift apart
  assign sel_own  = (req_in.addr == `OFS_OWN_ADDR);
  assign sel_refs = (req_in.addr == `OFS_REF_FB_SEL);
  assign sel_pri  = (req_in.addr == `OFS_PRIMARY_REF);
  assign sel_dis  = (req_in.addr == `OFS_REF_DIS_STATE);
  assign sel_ph   = (req_in.addr == `OFS_PREDIV_HIGH);
  assign sel_pm   = (req_in.addr == `OFS_PREDIV_MID);
  assign sel_pl   = (req_in.addr == `OFS_PREDIV_LOW);

  // write strobes per register; unmapped offsets are ignored
  assign wr_own = req_in.wr && sel_own;
  assign wr_sel = req_in.wr && sel_refs;
  assign wr_pri = req_in.wr && sel_pri;
  assign wr_dis = req_in.wr && sel_dis;
  assign wr_ph  = req_in.wr && sel_ph;
  assign wr_pm  = req_in.wr && sel_pm;
  assign wr_pl  = req_in.wr && sel_pl;

  // reserved bits of each written byte are dropped, so they cannot disturb fields
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr_sel) begin
      nxt_cfg.pll_reference_choice       = req_in.wdata[7:5];
      nxt_cfg.pll_feedback_choice        = req_in.wdata[4:2];
      nxt_cfg.revertive_switch_enable    = req_in.wdata[1];
      nxt_cfg.switchover_phase_behaviour = req_in.wdata[0];
    end
    if (wr_pri) begin
      nxt_cfg.primary_reference_choice = req_in.wdata[0];
    end
    if (wr_dis) begin
      nxt_cfg.reference1_exclude = req_in.wdata[`BIT_REF1_EXCLUDE];
      nxt_cfg.reference0_exclude = req_in.wdata[`BIT_REF0_EXCLUDE];
      nxt_cfg.state_ctrl         = req_in.wdata[1:0];
    end
    // most significant byte at the lowest offset
    if (wr_ph) begin
      nxt_cfg.reference0_predivider[20:16] = req_in.wdata[4:0];
    end
    if (wr_pm) begin
      nxt_cfg.reference0_predivider[15:8] = req_in.wdata;
    end
    if (wr_pl) begin
      nxt_cfg.reference0_predivider[7:0] = req_in.wdata;
    end
  end

  // read mux; reserved bits and unmapped offsets return zero
  assign nxt_rdata =
    sel_own  ? {1'b0, addr_upper_ff, strap_ff} :
    sel_refs ? {cfg_ff.pll_reference_choice, cfg_ff.pll_feedback_choice,
                cfg_ff.revertive_switch_enable,
                cfg_ff.switchover_phase_behaviour} :
    sel_pri  ? {7'h00, cfg_ff.primary_reference_choice} :
    sel_dis  ? {2'h0, cfg_ff.reference1_exclude, cfg_ff.reference0_exclude,
                2'h0, cfg_ff.state_ctrl} :
    sel_ph   ? {3'h0, cfg_ff.reference0_predivider[20:16]} :
    sel_pm   ? cfg_ff.reference0_predivider[15:8] :
    sel_pl   ? cfg_ff.reference0_predivider[7:0] :
               8'h00;

  pll_mode_decode pll_mode_decode_i (
    .ref_code_in         (nxt_cfg.pll_reference_choice),
    .state_code_in       (nxt_cfg.state_ctrl),
    .primary_in          (nxt_cfg.primary_reference_choice),
    .ref_auto_out        (dec_auto),
    .ref_gpio_out        (dec_gpio),
    .force_ref0_out      (dec_f0),
    .force_ref1_out      (dec_f1),
    .ref_code_bad_out    (dec_bad),
    .primary_is_ref1_out (dec_pri),
    .state_force_out     (dec_state)
  );

  // programmable upper address; generic power-up value completes 1111100b with straps low
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      addr_upper_ff <= `RST_ADDR_UPPER;
    end else if (wr_own) begin
      addr_upper_ff <= req_in.wdata[6:2];
    end
  end

  // strap pins follow the pins every cycle; writes never reach them
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      strap_ff <= 2'h0;
    end else begin
      strap_ff <= {address_strap_pin_1_in, address_strap_pin_0_in};
    end
  end

  // configuration store
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cfg_ff.pll_reference_choice       <= `RST_REF_CHOICE;
      cfg_ff.pll_feedback_choice        <= `RST_FB_CHOICE;
      cfg_ff.revertive_switch_enable    <= `RST_REVERTIVE;
      cfg_ff.switchover_phase_behaviour <= `RST_SWITCHOVER_PHASE_BEHAVIOUR;
      cfg_ff.primary_reference_choice   <= `RST_PRIMARY;
      cfg_ff.reference1_exclude         <= `RST_EXCLUDE;
      cfg_ff.reference0_exclude         <= `RST_EXCLUDE;
      cfg_ff.state_ctrl                 <= `RST_STATE_CTRL;
      cfg_ff.reference0_predivider      <= `RST_PREDIV;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // decoded controls registered alongside the store so they line up with pll_cfg_out
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ref_auto_ff     <= 1'b1;
      ref_gpio_ff     <= 1'b0;
      force_ref0_ff   <= 1'b0;
      force_ref1_ff   <= 1'b0;
      ref_code_bad_ff <= 1'b0;
      primary_ff      <= 1'b0;
      state_force_ff  <= 4'h1;
    end else begin
      ref_auto_ff     <= dec_auto;
      ref_gpio_ff     <= dec_gpio;
      force_ref0_ff   <= dec_f0;
      force_ref1_ff   <= dec_f1;
      ref_code_bad_ff <= dec_bad;
      primary_ff      <= dec_pri;
      state_force_ff  <= dec_state;
    end
  end

  // read data one cycle after the request
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= req_in.rd ? nxt_rdata : rdata_ff;
      rvalid_ff <= req_in.rd;
    end
  end

  assign rdata_out                  = rdata_ff;
  assign rvalid_out                 = rvalid_ff;
  assign own_bus_target_address_out = {addr_upper_ff, strap_ff};
  assign pll_cfg_out                = cfg_ff;
  assign ref_auto_out               = ref_auto_ff;
  assign ref_gpio_out               = ref_gpio_ff;
  assign force_ref0_out             = force_ref0_ff;
  assign force_ref1_out             = force_ref1_ff;
  assign ref_code_bad_out           = ref_code_bad_ff;
  assign primary_is_ref1_out        = primary_ff;
  assign state_force_out            = state_force_ff;
endmodule

// [sim/dpll_input_regs_chk.sv]
// Purpose: port assertions for the address and pll input register slice
// Assumes: ports of dpll_input_regs, one clock domain
// Notes:   bound from the bench top file
module dpll_input_regs_chk (
  input wire logic                   clock_in,
  input wire logic                   rst_in,
  input wire dpll_cfg_pkg::reg_req_t req_in,
  input wire logic                   address_strap_pin_1_in,
  input wire logic                   address_strap_pin_0_in,
  input wire logic [7:0]             rdata_out,
  input wire logic                   rvalid_out,
  input wire logic [6:0]             own_bus_target_address_out,
  input wire dpll_cfg_pkg::pll_cfg_t pll_cfg_out,
  input wire logic                   ref_auto_out,
  input wire logic                   ref_gpio_out,
  input wire logic                   force_ref0_out,
  input wire logic                   force_ref1_out,
  input wire logic                   ref_code_bad_out,
  input wire logic                   primary_is_ref1_out,
  input wire logic [3:0]             state_force_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // write strobes per offset
  wire w06 = req_in.wr && req_in.addr == 8'h06;
  wire w08 = req_in.wr && req_in.addr == 8'h08;
  wire w0a = req_in.wr && req_in.addr == 8'h0a;
  wire w0b = req_in.wr && req_in.addr == 8'h0b;
  addr_upper_a:
  assert property (w06 |=> own_bus_target_address_out[6:2] == $past(req_in.wdata[6:2])) else $error("addr upper");
  addr_bit7_a:
  assert property (req_in.rd && req_in.addr == 8'h06 |=> rvalid_out && !rdata_out[7]) else $error("addr bit7");
  strap_mirror_a:
  assert property (!$past(rst_in) |-> own_bus_target_address_out[1:0] ==
    {$past(address_strap_pin_1_in), $past(address_strap_pin_0_in)}) else $error("strap mirror");
  reset_values_a:
  assert property ($past(rst_in) |-> own_bus_target_address_out[6:2] == 5'h1f && pll_cfg_out[20:0] == 21'h0)
    else $error("reset values");
  ref_fb_write_a:
  assert property (w08 |=> pll_cfg_out[33:26] == $past(req_in.wdata)) else $error("ref fb write");
  dis_state_write_a:
  assert property (w0a |=> pll_cfg_out[24:21] == {$past(req_in.wdata[5:4]), $past(req_in.wdata[1:0])})
    else $error("disable state write");
  prediv_high_a:
  assert property (w0b |=> pll_cfg_out[20:16] == $past(req_in.wdata[4:0])) else $error("prediv high");
  ref_decode_a:
  assert property (force_ref1_out == (pll_cfg_out[33:31] == 3'h5) && force_ref0_out == (pll_cfg_out[33:31] == 3'h4)
    && ref_gpio_out == (pll_cfg_out[33:31] == 3'h1)) else $error("ref decode");
  ref_fallback_a:
  assert property (ref_code_bad_out == pll_cfg_out[32] &&
    ref_auto_out == (pll_cfg_out[32] || pll_cfg_out[33:31] == 3'h0)) else $error("ref fallback");
  state_decode_a:
  assert property (state_force_out == 4'h1 << pll_cfg_out[22:21]) else $error("state decode");
  primary_sel_a:
  assert property (primary_is_ref1_out == pll_cfg_out[25]) else $error("primary select");
endmodule

// [sim/cfg_host_model.sv]
// Purpose: register host on the far side of the request port
// Assumes: one request per call, released the edge after
// Notes:   reserved positions go out as zero, except bit 7 of 06, which goes out as given
module cfg_host_model (
  input  wire logic               clock_in,
  output dpll_cfg_pkg::reg_req_t  req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // reserved positions cleared; read-only bits of 06 go out as given, to show they are ignored
  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h06, 8'h08, 8'h0c, 8'h0d: mask = 8'hff;
      8'h09: mask = 8'h01;
      8'h0a: mask = 8'h33;
      8'h0b: mask = 8'h1f;
      default: mask = 8'h00;
    endcase
  endfunction
  initial req_out = '0;
  // request held over exactly one sampling edge
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    req_out <= '{wr: w, rd: !w, addr: a, wdata: w ? d & mask(a) : 8'h00};
    @(posedge clock_in);
    req_out <= '0;
  endtask
endmodule

// [sim/dpll_input_regs_tb.sv]
// Purpose: self-checking bench for the address and pll input register slice
// Assumes: host model drives requests, straps driven here
// Notes:   read results checked in order from a queue
module dpll_input_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock_in;
  logic                   rst_in;
  logic                   address_strap_pin_1_in;
  logic                   address_strap_pin_0_in;
  logic                   rvalid_out, ref_auto_out, ref_gpio_out, force_ref0_out;
  logic                   force_ref1_out, ref_code_bad_out, primary_is_ref1_out;
  logic [7:0]             rdata_out;
  logic [6:0]             own_bus_target_address_out;
  logic [3:0]             state_force_out;
  dpll_cfg_pkg::reg_req_t req_in;
  dpll_cfg_pkg::pll_cfg_t pll_cfg_out;
  logic [7:0]             exp_q[$];
  logic [15:0]            lfsr;
  logic [20:0]            pd;
  logic [7:0]             v;
  int                     bad_count;
  int                     checks_done;
  cfg_host_model cfg_host_model_i (.clock_in(clock_in), .req_out(req_in));
  dpll_input_regs dpll_input_regs_i (
    .clock_in                   (clock_in),
    .rst_in                     (rst_in),
    .req_in                     (req_in),
    .address_strap_pin_1_in     (address_strap_pin_1_in),
    .address_strap_pin_0_in     (address_strap_pin_0_in),
    .rdata_out                  (rdata_out),
    .rvalid_out                 (rvalid_out),
    .own_bus_target_address_out (own_bus_target_address_out),
    .pll_cfg_out                (pll_cfg_out),
    .ref_auto_out               (ref_auto_out),
    .ref_gpio_out               (ref_gpio_out),
    .force_ref0_out             (force_ref0_out),
    .force_ref1_out             (force_ref1_out),
    .ref_code_bad_out           (ref_code_bad_out),
    .primary_is_ref1_out        (primary_is_ref1_out),
    .state_force_out            (state_force_out)
  );
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  function automatic logic [15:0] step_lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cfg_host_model_i.access(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cfg_host_model_i.access(1'b1, a, d);
    @(negedge clock_in);
  endtask
  // read data settles mid-cycle; oldest note is the one due
  always @(negedge clock_in) begin
    if (rvalid_out === 1'b1) check(rdata_out, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end
  // a hang must not pass silently
  initial begin
    repeat (3000) @(posedge clock_in);
    bad_count++;
    finish_test();
  end
  initial begin
    rst_in = 1'b1;
    address_strap_pin_1_in = 1'b0;
    address_strap_pin_0_in = 1'b0;
    lfsr = 16'h8b0e;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    // power-up contents, reserved and unmapped offsets
    rd(8'h06, 8'h7c);
    rd(8'h07, 8'h00);
    rd(8'h08, 8'h03);
    rd(8'h09, 8'h00);
    rd(8'h0a, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h20, 8'h00);
    // upper address programmable, low bits follow the pins
    lfsr = step_lfsr(lfsr);
    address_strap_pin_1_in <= lfsr[1];
    address_strap_pin_0_in <= lfsr[0];
    wr(8'h06, 8'hd7);
    check(own_bus_target_address_out, {5'h15, lfsr[1:0]});
    rd(8'h06, {1'b0, 5'h15, lfsr[1:0]});
    // every reference code; unused ones fall back to automatic
    for (int c = 0; c < 8; c++) begin
      lfsr = step_lfsr(lfsr);
      v = {c[2:0], 1'b0, lfsr[3:0]};
      wr(8'h08, v);
      check({ref_auto_out, ref_gpio_out, force_ref0_out, force_ref1_out, ref_code_bad_out},
        {c == 0 || c[1], c == 1, c == 4, c == 5, c[1]});
      rd(8'h08, v);
    end
    for (int s = 0; s < 4; s++) begin
      lfsr = step_lfsr(lfsr);
      v = {2'h0, lfsr[1:0], 2'h0, s[1:0]};
      wr(8'h0a, v);
      check(state_force_out, 4'h1 << s);
      rd(8'h0a, v);
    end
    wr(8'h09, 8'h01);
    check(primary_is_ref1_out, 1'b1);
    wr(8'h09, 8'h00);
    check(primary_is_ref1_out, 1'b0);
    // random ratio, high byte first, no shadowing between bytes
    lfsr = step_lfsr(lfsr);
    pd = {lfsr[4:0], lfsr};
    wr(8'h0b, {3'h0, pd[20:16]});
    wr(8'h0c, pd[15:8]);
    wr(8'h0d, pd[7:0]);
    check(pll_cfg_out.reference0_predivider, pd);
    rd(8'h0b, {3'h0, pd[20:16]});
    // second reset in mid-run restores defaults
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(8'h0c, 8'h00);
    rd(8'h06, {1'b0, 5'h1f, address_strap_pin_1_in, address_strap_pin_0_in});
    repeat (3) @(posedge clock_in);
    finish_test();
  end
endmodule
bind dpll_input_regs dpll_input_regs_chk dpll_input_regs_chk_i (
  .clock_in                   (clock_in),
  .rst_in                     (rst_in),
  .req_in                     (req_in),
  .address_strap_pin_1_in     (address_strap_pin_1_in),
  .address_strap_pin_0_in     (address_strap_pin_0_in),
  .rdata_out                  (rdata_out),
  .rvalid_out                 (rvalid_out),
  .own_bus_target_address_out (own_bus_target_address_out),
  .pll_cfg_out                (pll_cfg_out),
  .ref_auto_out               (ref_auto_out),
  .ref_gpio_out               (ref_gpio_out),
  .force_ref0_out             (force_ref0_out),
  .force_ref1_out             (force_ref1_out),
  .ref_code_bad_out           (ref_code_bad_out),
  .primary_is_ref1_out        (primary_is_ref1_out),
  .state_force_out            (state_force_out)
);
